// ===== include/acl_consts.vh
// Constants for the ACL rule table indirect access block
`ifndef ACL_CONSTS_VH
`define ACL_CONSTS_VH
`define ACL_ADDR_W        12
`define ACL_OFF_STAGE0    12'h600
`define ACL_OFF_REMARK    12'h60b
`define ACL_OFF_SPARE     12'h60c
`define ACL_OFF_FWDMAP    12'h60d
`define ACL_OFF_RULE_HI   12'h60e
`define ACL_OFF_RULE_LO   12'h60f
`define ACL_OFF_SEL_HI    12'h610
`define ACL_OFF_SEL_LO    12'h611
`define ACL_OFF_CTRL      12'h612
`define ACL_OFF_IRQ_STAT  12'h620
`define ACL_OFF_IRQ_MASK  12'h621
`define ACL_NUM_BYTES     16
`define ACL_NUM_ENTRIES   16
`define ACL_CTRL_INDEX_HI 3
`define ACL_CTRL_WRITE    4
`define ACL_CTRL_RDDONE   5
`define ACL_CTRL_WRDONE   6
`define ACL_REMARK_LSB    7
`define ACL_REMARK_MSB_HI 1
`define ACL_MAPMODE_HI    6
`define ACL_MAPMODE_LO    5
`define ACL_FWD_HI        6
`define ACL_MODE_HI       5
`define ACL_MODE_LO       4
`define ACL_MODE_NONE     2'h0
`define ACL_MODE_L2       2'h1
`define ACL_MODE_L3       2'h2
`define ACL_MODE_L4       2'h3
`define ACL_RESET_BYTE    8'h00
`define ACL_IRQ_WRDONE    0
`define ACL_IRQ_RDDONE    1
`define ACL_XFER_CYCLES   16
`endif

// ===== src/acl_entry_ram.v
// Rule table storage with per-byte write enables
`timescale 1ns/1ns
`include "acl_consts.vh"
module acl_entry_ram #(
    parameter ENTRIES = `ACL_NUM_ENTRIES,
    parameter IDX_W   = 4
) (
    mclk,
    wrEn,
    addr,
    byteIdx,
    wrData,
    rdData
);
    input              mclk;
    input              wrEn;
    input  [IDX_W-1:0] addr;
    input  [3:0]       byteIdx;
    input  [7:0]       wrData;
    output [7:0]       rdData;
    wire               mclk;
    wire               wrEn;
    wire   [IDX_W-1:0] addr;
    wire   [3:0]       byteIdx;
    wire   [7:0]       wrData;
    reg    [7:0]       rdData;

    // One byte per word so untouched bytes keep their value
    reg [7:0] mem [0:ENTRIES*16-1];

    always @(posedge mclk) begin
        if (wrEn) begin
            mem[{addr, byteIdx}] <= wrData;
        end
        rdData <= mem[{addr, byteIdx}];
    end
endmodule // acl_entry_ram

// ===== src/acl_irq.v
// Sticky event status, mask and interrupt output
`timescale 1ns/1ns
module acl_irq #(
    parameter N = 2
) (
    mclk,
    nrst,
    evt,
    clrWr,
    clrData,
    maskWr,
    maskData,
    status,
    mask,
    irq
);
    input          mclk;
    input          nrst;
    input  [N-1:0] evt;
    input          clrWr;
    input  [N-1:0] clrData;
    input          maskWr;
    input  [N-1:0] maskData;
    output [N-1:0] status;
    output [N-1:0] mask;
    output         irq;
    wire           mclk;
    wire           nrst;
    wire   [N-1:0] evt;
    wire           clrWr;
    wire   [N-1:0] clrData;
    wire           maskWr;
    wire   [N-1:0] maskData;
    reg    [N-1:0] status;
    reg    [N-1:0] mask;
    wire           irq;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status <= {N{1'b0}};
            mask   <= {N{1'b0}};
        end else begin
            // Set beats clear in the same cycle
            status <= (status & ~(clrWr ? clrData : {N{1'b0}})) | evt;
            if (maskWr) begin
                mask <= maskData;
            end
        end
    end

    assign irq = |(status & mask);
endmodule // acl_irq

// ===== src/acl_table_access.v
// Per-port indirect access to the ACL rule table
//
// Operation
// - Remark priority LSB in bit 7
// - Seven-bit forward map, bit0 is port 1
// - High select bit7 picks offset 0
// - Low select bit7 picks offset 8
// - Low select write starts indexed transfer
// - Write status low while writing, reset high
// - Read status low while reading, reset high
// - Rule mode: none, L2, L3, L4
// - Remark priority MSBs in preceding byte
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "acl_consts.vh"
module acl_table_access (
    mclk,
    nrst,
    addr,
    wrData,
    wrStb,
    rdStb,
    rdData,
    ruleMode,
    remarkPrio,
    fwdPortMap,
    busy,
    irq
);
    input         mclk;
    input         nrst;
    input  [11:0] addr;
    input  [7:0]  wrData;
    input         wrStb;
    input         rdStb;
    output [7:0]  rdData;
    output [1:0]  ruleMode;
    output [2:0]  remarkPrio;
    output [6:0]  fwdPortMap;
    output        busy;
    output        irq;
    wire          mclk;
    wire          nrst;
    wire   [11:0] addr;
    wire   [7:0]  wrData;
    wire          wrStb;
    wire          rdStb;
    reg    [7:0]  rdData;
    wire   [1:0]  ruleMode;
    wire   [2:0]  remarkPrio;
    wire   [6:0]  fwdPortMap;
    wire          busy;
    wire          irq;

    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_WRITE = 3'b010;
    localparam [2:0] ST_READ  = 3'b100;

    // Staging bytes, offsets 0x600..0x60f
    reg  [7:0]  stage_reg [0:15];
    reg  [7:0]  selHi_reg;
    reg  [7:0]  selLo_reg;
    reg  [4:0]  ctrl_reg;
    reg         wrDone_reg;
    reg         rdDone_reg;
    reg  [2:0]  state_reg;
    reg  [4:0]  cnt_reg;
    reg  [15:0] xferSel_reg;
    reg  [3:0]  xferIdx_reg;
    reg         rdPend_reg;
    reg  [3:0]  rdByte_reg;
    reg  [2:0]  state_next;

    wire [1:0]  irqStatus;
    wire [1:0]  irqMask;
    wire        inStage;
    wire [3:0]  curByte;
    wire [7:0]  ramRd;
    wire        ramWr;
    wire        lastStep;
    wire [1:0]  evt;

    assign inStage = ((addr & 12'hff0) == `ACL_OFF_STAGE0);
    assign curByte = cnt_reg[3:0];
    assign lastStep = (cnt_reg == `ACL_XFER_CYCLES);
    assign ramWr = (state_reg == ST_WRITE) && !lastStep
                   && xferSel_reg[4'hf - curByte];

    acl_entry_ram #(
        .ENTRIES (`ACL_NUM_ENTRIES),
        .IDX_W   (4)
    ) uRam (
        .mclk    (mclk),
        .wrEn    (ramWr),
        .addr    (xferIdx_reg),
        .byteIdx (curByte),
        .wrData  (stage_reg[curByte]),
        .rdData  (ramRd)
    );

    always @* begin
        case (state_reg)
            ST_IDLE: begin
                if (wrStb && addr == `ACL_OFF_SEL_LO) begin
                    state_next = ctrl_reg[`ACL_CTRL_WRITE] ? ST_WRITE : ST_READ;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_WRITE: state_next = lastStep ? ST_IDLE : ST_WRITE;
            ST_READ:  state_next = lastStep ? ST_IDLE : ST_READ;
            default:  state_next = ST_IDLE;
        endcase
    end

    // Done events pulse on the last step
    assign evt[`ACL_IRQ_WRDONE] = (state_reg == ST_WRITE) && lastStep;
    assign evt[`ACL_IRQ_RDDONE] = (state_reg == ST_READ) && lastStep;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg   <= ST_IDLE;
            cnt_reg     <= 5'h00;
            xferSel_reg <= 16'h0000;
            xferIdx_reg <= 4'h0;
            wrDone_reg  <= 1'b1;
            rdDone_reg  <= 1'b1;
            rdPend_reg  <= 1'b0;
            rdByte_reg  <= 4'h0;
        end else begin
            state_reg <= state_next;
            rdPend_reg <= 1'b0;
            if (state_reg == ST_IDLE && state_next != ST_IDLE) begin
                cnt_reg     <= 5'h00;
                // Snapshot low select from the starting write itself;
                // bit 15-k of the combined select picks staging byte k
                xferSel_reg <= {selHi_reg, wrData};
                xferIdx_reg <= ctrl_reg[`ACL_CTRL_INDEX_HI:0];
                if (state_next == ST_WRITE) begin
                    wrDone_reg <= 1'b0;
                end else begin
                    rdDone_reg <= 1'b0;
                end
            end else if (state_reg != ST_IDLE) begin
                cnt_reg <= cnt_reg + 5'h01;
                if (state_reg == ST_READ && !lastStep) begin
                    rdPend_reg <= 1'b1;
                    rdByte_reg <= curByte;
                end
                if (lastStep) begin
                    if (state_reg == ST_WRITE) begin
                        wrDone_reg <= 1'b1;
                    end else begin
                        rdDone_reg <= 1'b1;
                    end
                end
            end
        end
    end

    // Staging bytes: host writes, plus read results one cycle after RAM read
    genvar g;
    generate
        for (g = 0; g < `ACL_NUM_BYTES; g = g + 1) begin : gStage
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    stage_reg[g] <= `ACL_RESET_BYTE;
                end else if (rdPend_reg && rdByte_reg == g
                             && xferSel_reg[15-g]) begin
                    stage_reg[g] <= ramRd;
                end else if (wrStb && inStage && addr[3:0] == g
                             && state_reg == ST_IDLE) begin
                    stage_reg[g] <= wrData;
                end
            end
        end
    endgenerate

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            selHi_reg <= 8'h00;
            selLo_reg <= 8'h00;
            ctrl_reg  <= 5'h00;
        end else if (wrStb) begin
            case (addr)
                `ACL_OFF_SEL_HI: selHi_reg <= wrData;
                `ACL_OFF_SEL_LO: selLo_reg <= wrData;
                `ACL_OFF_CTRL:   ctrl_reg  <= wrData[4:0];
                default: ;
            endcase
        end
    end

    acl_irq #(
        .N (2)
    ) uIrq (
        .mclk     (mclk),
        .nrst     (nrst),
        .evt      (evt),
        .clrWr    (wrStb && addr == `ACL_OFF_IRQ_STAT),
        .clrData  (wrData[1:0]),
        .maskWr   (wrStb && addr == `ACL_OFF_IRQ_MASK),
        .maskData (wrData[1:0]),
        .status   (irqStatus),
        .mask     (irqMask),
        .irq      (irq)
    );

    // Results are only trustworthy after read status rises
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdData <= 8'h00;
        end else if (rdStb) begin
            if (inStage) begin
                rdData <= stage_reg[addr[3:0]];
            end else begin
                case (addr)
                    `ACL_OFF_SEL_HI:   rdData <= selHi_reg;
                    `ACL_OFF_SEL_LO:   rdData <= selLo_reg;
                    `ACL_OFF_CTRL:     rdData <= {1'b0, wrDone_reg, rdDone_reg,
                                                  ctrl_reg};
                    `ACL_OFF_IRQ_STAT: rdData <= {6'h00, irqStatus};
                    `ACL_OFF_IRQ_MASK: rdData <= {6'h00, irqMask};
                    default:           rdData <= 8'h00;
                endcase
            end
        end else begin
            rdData <= 8'h00;
        end
    end

    // Decoded rule fields taken straight from staging
    assign ruleMode   = stage_reg[1][`ACL_MODE_HI:`ACL_MODE_LO];
    assign remarkPrio = {stage_reg[4'ha][`ACL_REMARK_MSB_HI:0],
                         stage_reg[4'hb][`ACL_REMARK_LSB]};
    assign fwdPortMap = stage_reg[4'hd][`ACL_FWD_HI:0];
    assign busy       = (state_reg != ST_IDLE);
endmodule // acl_table_access

// ===== test/acl_checker.sv
// Assertions on the ACL table access ports
`timescale 1ns/1ns
module acl_checker (
    input logic        mclk,
    input logic        nrst,
    input logic [11:0] addr,
    input logic [7:0]  wrData,
    input logic        wrStb,
    input logic        rdStb,
    input logic [7:0]  rdData,
    input logic [1:0]  ruleMode,
    input logic [2:0]  remarkPrio,
    input logic [6:0]  fwdPortMap,
    input logic        busy,
    input logic        irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Staging writes count only while idle
    wire ctlRd = rdStb && addr == 12'h612;
    wire idleWr = wrStb && !busy;
    sequence s_busy8;
        busy [*8];
    endsequence
    sequence s_run17;
        s_busy8 ##1 s_busy8 ##1 busy ##1 !busy;
    endsequence
    a_done_high: assert property (ctlRd && !busy |=> rdData[6:5] == 2'b11)
        else $error("done bits low while idle");
    a_busy_low: assert property (ctlRd && busy |=> rdData[6:5] != 2'b11)
        else $error("done bits high while busy");
    a_start_busy: assert property (idleWr && addr == 12'h611 |=> busy)
        else $error("no transfer started");
    a_busy_len: assert property ($rose(busy) |-> s_run17)
        else $error("transfer length wrong");
    a_fwd_map: assert property (idleWr && addr == 12'h60d
        |=> {1'b0, fwdPortMap} == ($past(wrData) & 8'h7f))
        else $error("forward map wrong");
    a_rule_mode: assert property (idleWr && addr == 12'h601
        |=> {2'b00, ruleMode, 4'h0} == ($past(wrData) & 8'h30))
        else $error("rule mode wrong");
    a_remark_lsb: assert property (idleWr && addr == 12'h60b
        |=> {remarkPrio[0], 7'h00} == ($past(wrData) & 8'h80))
        else $error("remark lsb wrong");
    a_remark_msb: assert property (idleWr && addr == 12'h60a
        |=> {6'h00, remarkPrio[2:1]} == ($past(wrData) & 8'h03))
        else $error("remark msbs wrong");
endmodule // acl_checker

bind acl_table_access acl_checker u_acl_checker (.mclk(mclk), .nrst(nrst), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .ruleMode(ruleMode),
    .remarkPrio(remarkPrio), .fwdPortMap(fwdPortMap), .busy(busy), .irq(irq));

// ===== test/tb.sv
// Self-checking bench for the ACL table access block
`timescale 1ns/1ns
module tb;
    logic        mclk;
    logic        nrst = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wrData = 8'h00;
    logic        wrStb = 1'b0;
    logic        rdStb = 1'b0;
    wire  [7:0]  rdData;
    wire  [1:0]  ruleMode;
    wire  [2:0]  remarkPrio;
    wire  [6:0]  fwdPortMap;
    wire         busy;
    wire         irq;
    integer      num_errors = 0;
    integer      n_tests = 0;
    integer      seed = 46454;
    logic [27:0] expQ[$];
    logic [27:0] e;
    logic        pend = 1'b0;
    logic [7:0]  tbl[16];
    logic [7:0]  stg[16];
    logic [11:0] ra[9] = '{12'h60c, 12'h60e, 12'h60f, 12'h610, 12'h611, 12'h612,
                           12'h620, 12'h621, 12'h6ff};

    acl_table_access u_acl_table_access (.mclk(mclk), .nrst(nrst), .addr(addr),
        .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .ruleMode(ruleMode),
        .remarkPrio(remarkPrio), .fwdPortMap(fwdPortMap), .busy(busy), .irq(irq));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    function void cmp(string n, logic [7:0] ex, logic [7:0] got, logic [7:0] m);
        n_tests++;
        if ((got & m) !== (ex & m)) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", n, ex & m, got & m);
        end
    endfunction

    // Read data stands only in the cycle after the strobe
    always @(posedge mclk) pend <= rdStb;
    always @(negedge mclk) begin
        if (pend) begin
            e = expQ.pop_front();
            cmp($sformatf("reg %h", e[27:16]), e[7:0], rdData, e[15:8]);
        end
    end

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        rdStb <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic [7:0] m);
        addr <= a;
        wrStb <= 1'b0;
        rdStb <= 1'b1;
        expQ.push_back({a, m, x});
        @(posedge mclk);
    endtask

    task automatic idle();
        wrStb <= 1'b0;
        rdStb <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic fill();
        for (int k = 0; k < 16; k++) begin
            stg[k] = 8'($random(seed));
            wr(12'h600 + 12'(k), stg[k]);
        end
    endtask

    task automatic xfer(input logic w, input logic [3:0] ix, input logic [7:0] hi,
                        input logic [7:0] lo, input logic poke);
        integer i;
        wr(12'h612, {3'b000, w, ix});
        wr(12'h610, hi);
        wr(12'h611, lo);
        rd(12'h612, 8'h00, w ? 8'h40 : 8'h20);
        // Staging write while busy must be ignored
        if (poke) wr(12'h603, ~stg[3]);
        idle();
        for (i = 0; i < 40 && busy !== 1'b0; i++) @(posedge mclk);
        if (busy !== 1'b0) begin
            num_errors++;
            report_and_stop();
        end
        rd(12'h612, {3'b011, w, ix}, 8'hff);
    endtask

    task report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        foreach (ra[i]) rd(ra[i], ra[i] == 12'h612 ? 8'h60 : 8'h00, 8'hff);
        for (int k = 0; k < 4; k++) begin
            wr(12'h601, 8'(k << 4));
            idle();
            cmp("ruleMode", 8'(k), {6'h00, ruleMode}, 8'hff);
        end
        fill();
        tbl = stg;
        idle();
        cmp("fwdPortMap", {1'b0, stg[13][6:0]}, {1'b0, fwdPortMap}, 8'hff);
        cmp("remarkPrio", {5'h00, stg[10][1:0], stg[11][7]},
            {5'h00, remarkPrio}, 8'hff);
        xfer(1'b1, 4'h5, 8'hff, 8'hff, 1'b0);
        // Partial write: offsets 4..11 only
        fill();
        for (int k = 4; k < 12; k++) tbl[k] = stg[k];
        xfer(1'b1, 4'h5, 8'h0f, 8'hf0, 1'b0);
        // Decoy entry catches an index that is ignored
        fill();
        xfer(1'b1, 4'h6, 8'hff, 8'hff, 1'b1);
        xfer(1'b0, 4'h5, 8'h81, 8'h81, 1'b0);
        stg[0] = tbl[0];
        stg[7] = tbl[7];
        stg[8] = tbl[8];
        stg[15] = tbl[15];
        for (int k = 0; k < 16; k++) rd(12'h600 + 12'(k), stg[k], 8'hff);
        rd(12'h620, 8'h03, 8'hff);
        idle();
        cmp("irq", 8'h00, {7'h00, irq}, 8'hff);
        wr(12'h621, 8'h02);
        idle();
        cmp("irq", 8'h01, {7'h00, irq}, 8'hff);
        wr(12'h620, 8'h02);
        rd(12'h620, 8'h01, 8'hff);
        idle();
        cmp("irq", 8'h00, {7'h00, irq}, 8'hff);
        idle();
        report_and_stop();
    end
endmodule // tb
